// >>> design/bit_tick.sv
// bit-rate divider: one-cycle enable pulse per transmitted bit
`timescale 1ns/1ps
module bit_tick #(
    parameter int CYCLES = txenc_pkg::BIT_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic en,
    output logic tick
);
    import txenc_pkg::*;

    typedef struct packed {
        logic [TICK_W-1:0] cnt;
        logic tick;
    } tick_state_t;

    localparam logic [TICK_W-1:0] LAST = TICK_W'(CYCLES - 1);

    tick_state_t st;
    tick_state_t next_st;

    // count while enabled; a stopped divider restarts a full period
    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (!en) begin
            next_st.cnt = '0;
        end else if (st.cnt == LAST) begin
            next_st.cnt = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + TICK_W'(1);
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;

    a_tick_period: assert property (@(posedge clk) disable iff (rst)
        tick |=> !tick) else $error("tick pulse lasted more than one cycle");
endmodule

// >>> design/byte_fifo.sv
// holding fifo with registered read data, valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0] cnt;
        logic [WIDTH-1:0] dout;
        logic dvalid;
    } fifo_state_t;

    fifo_state_t st;
    fifo_state_t next_st;
    logic push;
    logic fetch;

    // output word sits in a register; the array feeds it when it drains
    always_comb begin
        next_st = st;
        push = in_valid && in_ready;
        fetch = (st.cnt != '0) && (!st.dvalid || out_ready);
        if (out_valid && out_ready) begin
            next_st.dvalid = 1'b0;
        end
        if (fetch) begin
            next_st.dout = st.mem[st.rptr];
            next_st.dvalid = 1'b1;
            next_st.rptr = st.rptr + AW'(1);
        end
        if (push) begin
            next_st.mem[st.wptr] = in_data;
            next_st.wptr = st.wptr + AW'(1);
        end
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(fetch);
    end

    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign in_ready = (st.cnt != (AW+1)'(DEPTH));
    assign out_valid = st.dvalid;
    assign out_data = st.dout;
    assign level = st.cnt + (AW+1)'(st.dvalid);

    a_no_overflow: assert property (@(posedge clk) disable iff (rst)
        !in_ready |=> st.cnt == $past(st.cnt) - (AW+1)'($past(fetch)))
        else $error("fifo accepted a word while full");
endmodule

// >>> design/rf_tx_encoder_status_config.sv
// transmit control and status registers with encoder shifter and holding fifo
`timescale 1ns/1ps
module rf_tx_encoder_status_config (
    input wire logic clk,
    input wire logic rst,
    input wire logic wake,
    input wire txenc_pkg::sfr_req_t sfr,
    output logic [7:0] sfr_rdata,
    output logic hold_ready,
    input wire logic tx_enable,
    output logic tx_data,
    output logic tx_active,
    output txenc_pkg::rf_ctrl_t rf_ctrl
);
    import txenc_pkg::*;

    // ****************************************
    // decoding helpers
    // ****************************************

    // codes 01 and 10 give the same amplifier level
    function automatic pa_level_t power_level(input logic [1:0] code);
        case (code)
            2'b00: power_level = PA_5DBM;
            2'b11: power_level = PA_10DBM;
            default: power_level = PA_8DBM;
        endcase
    endfunction

    function automatic logic hit(input sfr_req_t r, input logic [7:0] a);
        hit = (r.addr == a);
    endfunction

    // ****************************************
    // signals
    // ****************************************
    enc_state_t st;
    enc_state_t next_st;
    logic tick;
    logic fifo_rst;
    logic push;
    logic fifo_valid;
    logic [7:0] fifo_data;
    logic [LEVEL_W-1:0] fifo_level;
    logic load;
    logic pop_last;
    logic idle_sym;
    logic invert;
    logic [7:0] status;

    // ****************************************
    // submodules
    // ****************************************

    // wake-up empties the pending data, configuration survives it
    assign fifo_rst = rst || wake;
    assign push = sfr.wr && hit(sfr, ADDR_HOLD) && hold_ready;

    byte_fifo #(
        .WIDTH(HOLD_WIDTH),
        .DEPTH(HOLD_DEPTH)
    ) u_hold (
        .clk(clk),
        .rst(fifo_rst),
        .in_valid(sfr.wr && hit(sfr, ADDR_HOLD)),
        .in_ready(hold_ready),
        .in_data(sfr.wdata),
        .out_valid(fifo_valid),
        .out_ready(load),
        .out_data(fifo_data),
        .level(fifo_level)
    );

    // bit clock only runs while the transmitter is switched on
    bit_tick #(
        .CYCLES(BIT_CYCLES)
    ) u_tick (
        .clk(clk),
        .rst(fifo_rst),
        .en(tx_enable),
        .tick(tick)
    );

    // ****************************************
    // encoder and register next state
    // ****************************************

    // load a new word on the tick that ends the last bit, or on any idle tick
    assign load = tick && fifo_valid &&
        (st.phase == PH_IDLE || st.bits_left == 4'h1);
    assign pop_last = load && (fifo_level == LEVEL_W'(1));
    assign idle_sym = st.enc_cfg[IDLE_BIT];
    assign invert = st.tx_config[INVERT_BIT];
    assign status = {6'h00, (st.bits_left == 4'h0), st.buf_full};

    always_comb begin
        next_st = st;
        // configuration writes; reserved bits never stored
        if (sfr.wr && hit(sfr, ADDR_TX_CONFIG)) begin
            next_st.tx_config = sfr.wdata & TX_CONFIG_MASK;
        end
        if (sfr.wr && hit(sfr, ADDR_OSC_CONFIG)) begin
            next_st.osc_config = sfr.wdata;
        end
        if (sfr.wr && hit(sfr, ADDR_ENC_CFG)) begin
            next_st.enc_cfg = sfr.wdata & ENC_CFG_MASK;
        end
        // set on write beats a clear from the last pop
        if (push) begin
            next_st.buf_full = 1'b1;
        end else if (pop_last) begin
            next_st.buf_full = 1'b0;
        end
        // shifter: msb first, configured length of one to eight bits
        if (tick) begin
            if (load) begin
                next_st.shreg = fifo_data;
                next_st.bits_left = {1'b0, st.enc_cfg[LEN_LSB +: 3]} + 4'h1;
                next_st.phase = PH_SEND;
            end else if (st.phase == PH_SEND && st.bits_left > 4'h1) begin
                next_st.shreg = {st.shreg[6:0], 1'b0};
                next_st.bits_left = st.bits_left - 4'h1;
            end else begin
                next_st.bits_left = 4'h0;
                next_st.phase = PH_IDLE;
            end
        end
        // wake-up returns the status to empty without touching configuration
        if (wake) begin
            next_st.buf_full = 1'b0;
            next_st.bits_left = 4'h0;
            next_st.phase = PH_IDLE;
        end
        // modulator data: quiescent symbol when nothing is shifting
        if (next_st.phase == PH_SEND) begin
            next_st.txd = next_st.shreg[7] ^ next_st.tx_config[INVERT_BIT];
        end else begin
            next_st.txd = next_st.enc_cfg[IDLE_BIT] ^ next_st.tx_config[INVERT_BIT];
        end
        // register reads; write-only and unmapped addresses read zero
        if (sfr.rd) begin
            case (sfr.addr)
                ADDR_STATUS: next_st.rdata = status;
                ADDR_OSC_CONFIG: next_st.rdata = st.osc_config;
                ADDR_ENC_CFG: next_st.rdata = st.enc_cfg;
                default: next_st.rdata = 8'h00;
            endcase
        end
    end

    // ****************************************
    // state register
    // ****************************************

    // reset values; status bits come out as 02
    always_ff @(posedge clk) begin
        if (rst) begin
            st.tx_config <= RST_TX_CONFIG;
            st.osc_config <= RST_OSC_CONFIG;
            st.enc_cfg <= RST_ENC_CFG;
            st.buf_full <= RST_STATUS[FULL_BIT];
            st.phase <= PH_IDLE;
            st.shreg <= 8'h00;
            st.bits_left <= 4'h0;
            st.rdata <= 8'h00;
            st.txd <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // outputs to the analog chain
    // ****************************************
    assign sfr_rdata = st.rdata;
    assign tx_data = st.txd;
    assign tx_active = (st.phase == PH_SEND);
    assign rf_ctrl.cap_short = st.tx_config[CAP_SHORT_BIT];
    assign rf_ctrl.mod_ask = st.tx_config[MOD_BIT];
    assign rf_ctrl.band = band_t'(st.tx_config[BAND_LSB +: 2]);
    assign rf_ctrl.pa_code = st.tx_config[POWER_LSB +: 2];
    assign rf_ctrl.pa_level = power_level(st.tx_config[POWER_LSB +: 2]);
    // current in uA is the code times the step size
    assign rf_ctrl.core_current = st.osc_config[CORE_CUR_LSB +: 4];
    assign rf_ctrl.tuning_curve = st.osc_config[TUNE_LSB +: 4];

    // ****************************************
    // assertions
    // ****************************************
    a_full_on_write: assert property (@(posedge clk) disable iff (rst)
        push && !wake |=> st.buf_full)
        else $error("buffer full not set after holding write");

    a_full_clears: assert property (@(posedge clk) disable iff (rst)
        pop_last && !push |=> !st.buf_full)
        else $error("buffer full not cleared after last transfer");

    a_empty_flag: assert property (@(posedge clk) disable iff (rst)
        load && !wake |=> status[EMPTY_BIT] == 1'b0 ##0 tx_active)
        else $error("shift empty still set after load");

    a_status_read: assert property (@(posedge clk) disable iff (rst)
        sfr.rd && sfr.addr == ADDR_STATUS |=>
        sfr_rdata == {6'h00, $past(st.bits_left) == 4'h0, $past(st.buf_full)})
        else $error("status read returned wrong value");

    a_status_reset: assert property (@(posedge clk) disable iff (rst)
        $fell(rst) |-> status == RST_STATUS && st.tx_config == RST_TX_CONFIG)
        else $error("status or tx config not at reset value");

    a_idle_symbol: assert property (@(posedge clk) disable iff (rst)
        !tx_active |-> tx_data == (idle_sym ^ invert))
        else $error("idle symbol wrong on modulator");

    a_invert_data: assert property (@(posedge clk) disable iff (rst)
        load && !wake |=> tx_data == ($past(fifo_data[7]) ^ invert))
        else $error("first data bit not sent msb first with inversion");

    a_tx_fields: assert property (@(posedge clk) disable iff (rst)
        sfr.wr && sfr.addr == ADDR_TX_CONFIG |=>
        rf_ctrl.mod_ask == $past(sfr.wdata[MOD_BIT]) &&
        rf_ctrl.band == band_t'($past(sfr.wdata[BAND_LSB +: 2])) &&
        rf_ctrl.cap_short == $past(sfr.wdata[CAP_SHORT_BIT]) &&
        st.tx_config[4] == 1'b0)
        else $error("tx config write not applied");

    a_power_map: assert property (@(posedge clk) disable iff (rst)
        rf_ctrl.pa_code == 2'b10 || rf_ctrl.pa_code == 2'b01 |->
        rf_ctrl.pa_level == PA_8DBM)
        else $error("power codes one and two differ");

    // a read two cycles after the write, with no write between, must return that write
    a_osc_readback: assert property (@(posedge clk) disable iff (rst)
        sfr.wr && sfr.addr == ADDR_OSC_CONFIG ##1 !sfr.wr ##1
        sfr.rd && sfr.addr == ADDR_OSC_CONFIG |=> sfr_rdata == $past(sfr.wdata, 3))
        else $error("osc config readback mismatch");

    a_bit_count: assert property (@(posedge clk) disable iff (rst)
        load && !wake |=> st.bits_left == {1'b0, $past(st.enc_cfg[LEN_LSB +: 3])} + 4'h1)
        else $error("wrong bit count loaded");

    a_tx_cfg_wo: assert property (@(posedge clk) disable iff (rst)
        sfr.rd && sfr.addr == ADDR_TX_CONFIG |=> sfr_rdata == 8'h00)
        else $error("write-only tx config returned data");
endmodule

// >>> inc/txenc_pkg.sv
// package: register map, field layout, timing and carrier types of the tx encoder block
package txenc_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ADDR_TX_CONFIG = 8'hae;
    localparam logic [7:0] ADDR_OSC_CONFIG = 8'hde;
    localparam logic [7:0] ADDR_STATUS = 8'he6;
    localparam logic [7:0] ADDR_HOLD = 8'he5;
    localparam logic [7:0] ADDR_ENC_CFG = 8'he7;
    localparam logic [7:0] RST_TX_CONFIG = 8'h07;
    localparam logic [7:0] RST_OSC_CONFIG = 8'h90;
    localparam logic [7:0] RST_STATUS = 8'h02;
    localparam logic [7:0] RST_ENC_CFG = 8'he0;
    // reserved bit four of tx config is kept at zero
    localparam logic [7:0] TX_CONFIG_MASK = 8'hef;
    localparam logic [7:0] ENC_CFG_MASK = 8'he8;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CAP_SHORT_BIT = 7;
    localparam int INVERT_BIT = 6;
    localparam int MOD_BIT = 5;
    localparam int BAND_LSB = 2;
    localparam int POWER_LSB = 0;
    localparam int CORE_CUR_LSB = 4;
    localparam int TUNE_LSB = 0;
    localparam int LEN_LSB = 5;
    localparam int IDLE_BIT = 3;
    localparam int FULL_BIT = 0;
    localparam int EMPTY_BIT = 1;
    localparam int CORE_STEP_UA = 200;

    // ****************************************
    // timing and buffering
    // ****************************************
    localparam int CLK_PERIOD_NS = 4;
    localparam int BIT_TIME_NS = 4000;
    localparam int BIT_CYCLES = BIT_TIME_NS / CLK_PERIOD_NS;
    localparam int TICK_W = 16;
    localparam int HOLD_WIDTH = 8;
    localparam int HOLD_DEPTH = 32;
    localparam int LEVEL_W = $clog2(HOLD_DEPTH) + 1;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {BAND_315, BAND_434, BAND_868, BAND_915} band_t;
    typedef enum logic [1:0] {PA_5DBM, PA_8DBM, PA_10DBM} pa_level_t;
    typedef enum logic {PH_IDLE, PH_SEND} phase_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef struct packed {
        logic cap_short;
        logic mod_ask;
        band_t band;
        logic [1:0] pa_code;
        pa_level_t pa_level;
        logic [3:0] core_current;
        logic [3:0] tuning_curve;
    } rf_ctrl_t;

    typedef struct packed {
        logic [7:0] tx_config;
        logic [7:0] osc_config;
        logic [7:0] enc_cfg;
        logic buf_full;
        phase_t phase;
        logic [7:0] shreg;
        logic [3:0] bits_left;
        logic [7:0] rdata;
        logic txd;
    } enc_state_t;

endpackage

// >>> test/rf_front_model.sv
// behavioural model of the rf front end: bit sampler plus band and power readout
`timescale 1ns/1ps
module rf_front_model (
    input wire logic clk,
    input wire logic tx_data,
    input wire logic tx_active,
    input wire txenc_pkg::rf_ctrl_t rf_ctrl,
    output logic frame_done,
    output logic [7:0] frame_bits,
    output logic [3:0] frame_len,
    output logic [15:0] band_mhz,
    output logic [15:0] pa_dbm
);
    import txenc_pkg::*;
    int cnt = 0;
    logic [7:0] acc = 8'h00;
    logic [3:0] got = 4'h0;

    // ****************************************
    // bit sampler
    // ****************************************
    // read halfway into each bit, away from the moments the encoder moves the line
    always @(negedge clk) begin
        frame_done = 1'b0;
        if (tx_active === 1'b1) begin
            if (cnt % BIT_CYCLES == BIT_CYCLES / 2) begin
                acc = {acc[6:0], tx_data};
                got = got + 4'h1;
            end
            cnt = cnt + 1;
        end else begin
            // a frame ends when the shifter reports empty
            if (got != 4'h0) begin
                frame_bits = acc;
                frame_len = got;
                frame_done = 1'b1;
            end
            cnt = 0;
            acc = 8'h00;
            got = 4'h0;
        end
    end

    // ****************************************
    // synthesizer and amplifier readout
    // ****************************************
    // unknown codes map to zero so a bad field never looks like a valid range
    always_comb begin
        case (rf_ctrl.band)
            BAND_315: band_mhz = 16'd315;
            BAND_434: band_mhz = 16'd434;
            BAND_868: band_mhz = 16'd868;
            BAND_915: band_mhz = 16'd915;
            default: band_mhz = 16'd0;
        endcase
        case (rf_ctrl.pa_level)
            PA_5DBM: pa_dbm = 16'd5;
            PA_8DBM: pa_dbm = 16'd8;
            PA_10DBM: pa_dbm = 16'd10;
            default: pa_dbm = 16'd0;
        endcase
    end
endmodule

// >>> test/tb_top.sv
// testbench: register access, holding fifo and bit stream checks of the tx encoder
`timescale 1ns/1ps
module tb_top;
    import txenc_pkg::*;
    typedef struct {string name; logic [15:0] val;} note_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wake = 1'b0;
    logic tx_enable = 1'b0;
    logic rd_seen = 1'b0;
    sfr_req_t sfr = '0;
    logic [7:0] sfr_rdata, frame_bits, v, osc_v;
    logic hold_ready, tx_data, tx_active, frame_done;
    logic [3:0] frame_len;
    logic [15:0] band_mhz, pa_dbm;
    rf_ctrl_t rf_ctrl;
    note_t read_q[$], frame_q[$], nr, nf;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [15:0] mhz_tab[4] = '{16'd315, 16'd434, 16'd868, 16'd915};
    logic [15:0] dbm_tab[4] = '{16'd5, 16'd8, 16'd8, 16'd10};

    always #2 clk = ~clk;

    rf_tx_encoder_status_config dut (.clk(clk), .rst(rst), .wake(wake), .sfr(sfr),
        .sfr_rdata(sfr_rdata), .hold_ready(hold_ready), .tx_enable(tx_enable),
        .tx_data(tx_data), .tx_active(tx_active), .rf_ctrl(rf_ctrl));
    rf_front_model front (.clk(clk), .tx_data(tx_data), .tx_active(tx_active),
        .rf_ctrl(rf_ctrl), .frame_done(frame_done), .frame_bits(frame_bits),
        .frame_len(frame_len), .band_mhz(band_mhz), .pa_dbm(pa_dbm));

    // ****************************************
    // checking and bus tasks
    // ****************************************
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr.addr = a;
        sfr.wdata = d;
        sfr.wr = 1'b1;
        @(negedge clk);
        sfr.wr = 1'b0;
    endtask

    // the expected value is noted; the read monitor does the comparing
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string name);
        @(negedge clk);
        sfr.addr = a;
        sfr.rd = 1'b1;
        read_q.push_back(note_t'{name, {8'h00, e}});
        @(negedge clk);
        sfr.rd = 1'b0;
    endtask

    task automatic wait_active(input logic lvl, input int lim);
        for (int i = 0; i < lim && tx_active !== lvl; i++) @(negedge clk);
        check("tx_active", {15'd0, tx_active}, {15'd0, lvl});
    endtask

    // one byte through holding fifo and shifter, then the idle symbol
    task automatic send(input logic [2:0] len, input logic idle, input logic inv,
        input logic [7:0] b);
        int n;
        logic [7:0] m;
        n = len + 1;
        m = 8'hff >> (8 - n);
        wr(ADDR_ENC_CFG, {len, 1'b0, idle, 3'b000});
        wr(ADDR_TX_CONFIG, {1'b0, inv, 6'h07});
        frame_q.push_back(note_t'{"frame", {4'(n), (b >> (8 - n)) ^ (inv ? m : 8'h00)}});
        wr(ADDR_HOLD, b);
        wait_active(1'b1, 2 * BIT_CYCLES);
        rd(ADDR_STATUS, 8'h00, "status sending");
        wait_active(1'b0, 9 * BIT_CYCLES);
        @(negedge clk);
        check("idle symbol", {15'd0, tx_data}, {15'd0, idle ^ inv});
        rd(ADDR_STATUS, RST_STATUS, "status drained");
        $display("test frame of %0d bits done", n);
    endtask

    // ****************************************
    // monitors
    // ****************************************
    // read data lands one cycle after the strobe is taken
    always @(posedge clk) rd_seen <= sfr.rd;
    always @(negedge clk) begin
        if (rd_seen === 1'b1 && read_q.size() > 0) begin
            nr = read_q.pop_front();
            check(nr.name, {8'h00, sfr_rdata}, nr.val);
        end
    end
    always @(posedge clk) begin
        if (frame_done === 1'b1 && frame_q.size() > 0) begin
            nf = frame_q.pop_front();
            check(nf.name, {4'h0, frame_len, frame_bits}, nf.val);
        end
    end
    // hang guard, well above the three frames plus register traffic
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            $display("timeout after %0d cycles", cycles);
            conclude();
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        void'($urandom(62));
        repeat (16) @(negedge clk);
        rst = 1'b0;
        rd(ADDR_OSC_CONFIG, RST_OSC_CONFIG, "osc reset");
        rd(ADDR_STATUS, RST_STATUS, "status reset");
        rd(ADDR_TX_CONFIG, 8'h00, "tx_config reset");
        rd(8'h10, 8'h00, "unmapped");
        rd(ADDR_ENC_CFG, RST_ENC_CFG, "enc reset");
        check("rf reset", rf_ctrl, {4'b0001, 4'b1110, 8'h90});
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
            osc_v = v;
            wr(ADDR_OSC_CONFIG, v);
            rd(ADDR_OSC_CONFIG, v, "osc rw");
            check("core current", {12'd0, rf_ctrl.core_current}, {12'd0, v[7:4]});
            check("tuning curve", {12'd0, rf_ctrl.tuning_curve}, {12'd0, v[3:0]});
        end
        $display("test osc_config done");
        for (int c = 0; c < 16; c++) begin
            v = {3'($urandom), 1'($urandom), 4'(c)};
            wr(ADDR_TX_CONFIG, v);
            @(negedge clk);
            check("cap short", {15'd0, rf_ctrl.cap_short}, {15'd0, v[7]});
            check("modulation", {15'd0, rf_ctrl.mod_ask}, {15'd0, v[5]});
            check("band", band_mhz, mhz_tab[c / 4]);
            check("power code", {14'd0, rf_ctrl.pa_code}, {14'd0, v[1:0]});
            check("power", pa_dbm, dbm_tab[c % 4]);
        end
        rd(ADDR_TX_CONFIG, 8'h00, "tx_config wo");
        wr(ADDR_STATUS, 8'hff);
        rd(ADDR_STATUS, RST_STATUS, "status ro");
        $display("test tx_config done");
        for (int i = 0; i < HOLD_DEPTH + 1; i++) begin
            check("hold ready", {15'd0, hold_ready}, 16'd1);
            wr(ADDR_HOLD, 8'(i));
        end
        @(negedge clk);
        check("hold full", {15'd0, hold_ready}, 16'd0);
        wr(ADDR_HOLD, 8'h5a);
        rd(ADDR_STATUS, 8'h03, "status full");
        @(negedge clk);
        wake = 1'b1;
        @(negedge clk);
        wake = 1'b0;
        rd(ADDR_STATUS, RST_STATUS, "status wake");
        rd(ADDR_OSC_CONFIG, osc_v, "osc kept");
        check("hold after wake", {15'd0, hold_ready}, 16'd1);
        $display("test fill and wake done");
        tx_enable = 1'b1;
        send(3'd7, 1'b0, 1'b0, 8'ha5);
        send(3'd2, 1'b1, 1'b1, 8'($urandom));
        send(3'd0, 1'b0, 1'b1, 8'h80);
        repeat (4) @(negedge clk);
        check("pending notes", 16'(read_q.size() + frame_q.size()), 16'd0);
        conclude();
    end
endmodule
